// >>> testbench/lsag_props.sv
// concurrent checks on the address generator ports
`timescale 1ns/1ps
module lsag_props (
  input wire        clk,
  input wire        resetn,
  input wire        req_valid,
  input wire [3:0]  mode,
  input wire [17:0] abs_const,
  input wire [15:0] offset,
  input wire [31:0] addr_even,
  input wire [31:0] addr_odd,
  input wire [31:0] pc,
  input wire        acc_valid_q,
  input wire [31:0] eff_addr_q,
  input wire        wb_even_q,
  input wire [31:0] wb_even_data_q,
  input wire        link_wr_q,
  input wire [31:0] link_data_q,
  input wire        alignment_trap_q,
  input wire        mem_trap_q
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  wire [31:0] sum_s   = addr_even + {{22{offset[9]}}, offset[9:0]};
  wire [31:0] abs_ea  = {abs_const[17:14], 14'h0, abs_const[13:0]};
  wire [31:0] circ_ea = addr_even + {16'h0, addr_odd[15:0]};
  wire [31:0] link_ea = pc + 32'h4;
  wire        same_sg = sum_s[31:28] == addr_even[31:28];
  chk_abs_addr: assert property (req_valid && mode == 4'h0 |=> eff_addr_q == $past(abs_ea))
    else $error("absolute address wrong");
  chk_short_addr: assert property (req_valid && mode == 4'h1 && same_sg |=>
    acc_valid_q && eff_addr_q == $past(sum_s))
    else $error("short offset address wrong");
  chk_short_cross: assert property (req_valid && mode == 4'h1 && !same_sg |=> mem_trap_q && !acc_valid_q)
    else $error("segment crossing not trapped");
  chk_pre_wb: assert property (req_valid && mode == 4'h3 && same_sg |=> wb_even_q &&
    wb_even_data_q == eff_addr_q && eff_addr_q == $past(sum_s))
    else $error("pre-increment mismatch");
  chk_post_pair: assert property (req_valid && mode == 4'h4 |=> eff_addr_q == $past(addr_even) &&
    wb_even_data_q == $past(sum_s))
    else $error("post-increment mismatch");
  chk_link_addr: assert property (req_valid && mode == 4'h9 |=> link_wr_q && link_data_q == $past(link_ea))
    else $error("link address wrong");
  chk_trap_blocks: assert property (alignment_trap_q || mem_trap_q |->
    !acc_valid_q && !wb_even_q)
    else $error("trapped access went ahead");
  chk_periph_trap: assert property (req_valid && mode == 4'h5 && circ_ea[31:28] == 4'hf |=>
    !acc_valid_q && (mem_trap_q || alignment_trap_q))
    else $error("circular peripheral access not trapped");
  cover property (req_valid && mode == 4'h5 ##1 acc_valid_q);
  cover property (alignment_trap_q);
  cover property (mem_trap_q);
endmodule // lsag_props
bind load_store_address_generator lsag_props u_props (.clk(clk), .resetn(resetn), .req_valid(req_valid),
  .mode(mode), .abs_const(abs_const), .offset(offset), .addr_even(addr_even), .addr_odd(addr_odd), .pc(pc),
  .acc_valid_q(acc_valid_q), .eff_addr_q(eff_addr_q), .wb_even_q(wb_even_q), .wb_even_data_q(wb_even_data_q),
  .link_wr_q(link_wr_q), .link_data_q(link_data_q), .alignment_trap_q(alignment_trap_q), .mem_trap_q(mem_trap_q));

// >>> testbench/pair_regs.sv
// address register pair standing in for the core register file
`timescale 1ns/1ps
module pair_regs (
  input  wire        clk,
  input  wire        resetn,
  input  wire        load,
  input  wire [31:0] load_even,
  input  wire [31:0] load_odd,
  input  wire        wb_even,
  input  wire [31:0] wb_even_data,
  input  wire        wb_odd,
  input  wire [31:0] wb_odd_data,
  output reg  [31:0] even_q,
  output reg  [31:0] odd_q
);
  // a preload wins over a late write-back so each case starts clean
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      even_q <= 32'h0;
      odd_q <= 32'h0;
    end else if (load) begin
      even_q <= load_even;
      odd_q <= load_odd;
    end else begin
      if (wb_even) even_q <= wb_even_data;
      if (wb_odd) odd_q <= wb_odd_data;
    end
  end
endmodule // pair_regs

// >>> testbench/testbench.sv
// self-checking bench for the load/store address generator
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [3:0]  m;
    logic [1:0]  sz;
    logic [15:0] off;
    logic [31:0] ev, od, dat, eff, wb;
    logic [1:0]  tr;
  } row_t;
  row_t         rows [14];
  row_t         r;
  logic         clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, load = 1'b0;
  logic [3:0]   mode = 4'h0;
  logic [1:0]   access_size = 2'h0;
  logic [15:0]  offset = 16'h0;
  logic [15:0]  brev_seq [5];
  logic [3:0]   fl;
  logic [31:0]  got;
  logic [31:0]  pe = 32'h0, po = 32'h0, data_reg = 32'h0, even, odd;
  logic         acc_valid_q, wb_even_q, wb_odd_q, link_wr_q, jump_q, alignment_trap_q, mem_trap_q;
  logic [31:0]  eff_addr_q, wb_even_data_q, wb_odd_data_q, link_data_q, jump_addr_q;
  logic [255:0] lane_addr_q;
  int           bad_count = 0, n_compared = 0, i;
  always #5 clk = ~clk;
  load_store_address_generator dut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .mode(mode),
    .access_size(access_size), .abs_const(data_reg[17:0]), .offset(offset), .scale_sel(access_size),
    .addr_even(even), .addr_odd(odd), .data_reg(data_reg), .pc(data_reg), .jump_target(pe),
    .acc_valid_q(acc_valid_q), .eff_addr_q(eff_addr_q), .lane_addr_q(lane_addr_q), .wb_even_q(wb_even_q),
    .wb_even_data_q(wb_even_data_q), .wb_odd_q(wb_odd_q), .wb_odd_data_q(wb_odd_data_q), .link_wr_q(link_wr_q),
    .link_data_q(link_data_q), .jump_q(jump_q), .jump_addr_q(jump_addr_q), .alignment_trap_q(alignment_trap_q),
    .mem_trap_q(mem_trap_q));
  pair_regs pm (.clk(clk), .resetn(resetn), .load(load), .load_even(pe), .load_odd(po), .wb_even(wb_even_q),
    .wb_even_data(wb_even_data_q), .wb_odd(wb_odd_q), .wb_odd_data(wb_odd_data_q), .even_q(even), .odd_q(odd));
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // the preload is captured on the first edge, the request on the next
  task go(input logic [3:0] m, input logic [15:0] o);
    @(posedge clk);
    #1;
    load = 1'b0;
    req_valid = 1'b1;
    mode = m;
    offset = o;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
  initial begin
    rows = '{'{4'h0, 2'h0, 16'h0, 32'h0, 32'h0, 32'h0003c123, 32'hf0000123, 32'h0, 2'h0},
      '{4'h2, 2'h0, 16'h8000, 32'h10010000, 32'h0, 32'h0, 32'h10008000, 32'h0, 2'h0},
      '{4'h3, 2'h0, 16'h03f0, 32'h20000100, 32'h0, 32'h0, 32'h200000f0, 32'h200000f0, 2'h0},
      '{4'h4, 2'h0, 16'h03f8, 32'h30000100, 32'h0, 32'h0, 32'h30000100, 32'h300000f8, 2'h0},
      '{4'h5, 2'h1, 16'h03f8, 32'h2000, 32'h00320004, 32'h0, 32'h2004, 32'h0032002e, 2'h0},
      '{4'h5, 2'h1, 16'h0004, 32'h2000, 32'h00320030, 32'h0, 32'h2030, 32'h00320002, 2'h0},
      '{4'h8, 2'h0, 16'h0, 32'h1001, 32'h0, 32'h35, 32'h0, 32'h1004, 2'h0},
      '{4'h9, 2'h0, 16'h0, 32'h80002000, 32'h0, 32'h80000100, 32'h0, 32'h80000104, 2'h0},
      '{4'h5, 2'h1, 16'h0002, 32'h2004, 32'h00320000, 32'h0, 32'h0, 32'h0, 2'h2},
      '{4'h5, 2'h2, 16'h0004, 32'h2000, 32'h00320000, 32'h0, 32'h0, 32'h0, 2'h2},
      '{4'h5, 2'h1, 16'h0002, 32'h2000, 32'h00320032, 32'h0, 32'h0, 32'h0, 2'h2},
      '{4'h5, 2'h1, 16'h0002, 32'hf0000000, 32'h00100000, 32'h0, 32'h0, 32'h0, 2'h1},
      '{4'h1, 2'h0, 16'h0008, 32'h1ffffffc, 32'h0, 32'h0, 32'h0, 32'h0, 2'h1},
      '{4'h1, 2'h0, 16'h03fc, 32'h40000010, 32'h0, 32'h0, 32'h4000000c, 32'h0, 2'h0}};
    brev_seq = '{16'h0000, 16'h0400, 16'h0200, 16'h0600, 16'h0100};
    repeat (3) @(posedge clk);
    #1;
    chk({acc_valid_q, mem_trap_q, eff_addr_q[29:0]}, 32'h0);
    $display("reset test done");
    resetn = 1'b1;
    for (i = 0; i < 14; i++) begin
      r = rows[i];
      access_size = r.sz;
      data_reg = r.dat;
      pe = r.ev;
      po = r.od;
      load = 1'b1;
      go(r.m, r.off);
      chk({alignment_trap_q, mem_trap_q}, r.tr);
      if (r.m < 4'h7) chk(acc_valid_q, r.tr == 2'h0);
      if (r.m < 4'h7 && r.tr == 2'h0) chk(eff_addr_q, r.eff);
      got = r.m == 4'h9 ? link_data_q : r.m == 4'h5 ? wb_odd_data_q : wb_even_data_q;
      if (r.m > 4'h2 && r.tr == 2'h0) chk(got, r.wb);
      case (r.m)
        4'h3, 4'h4, 4'h7, 4'h8: fl = 4'h8;
        4'h5, 4'h6: fl = 4'h4;
        4'h9: fl = 4'h3;
        default: fl = 4'h0;
      endcase
      if (r.tr != 2'h0) fl = 4'h0;
      chk({wb_even_q, wb_odd_q, link_wr_q, jump_q}, {28'h0, fl});
      if (r.m == 4'h9) chk(jump_addr_q, r.ev);
      $display("row %0d done", i);
    end
    for (i = 0; i < 4; i++) begin
      access_size = i[1:0];
      data_reg = 32'h5;
      pe = 32'h100;
      load = 1'b1;
      go(4'h7, 16'h0);
      chk(wb_even_data_q, 32'h100 + (32'h5 << i));
    end
    $display("scaled test done");
    load = 1'b1;
    go(4'hb, 16'h0);
    chk({acc_valid_q, wb_even_q, wb_odd_q, link_wr_q, jump_q, alignment_trap_q, mem_trap_q}, 32'h0);
    $display("unknown mode test done");
    pe = 32'h2000;
    po = 32'h00340032;
    access_size = 2'h2;
    load = 1'b1;
    go(4'h5, 16'h0002);
    chk(lane_addr_q[31:0], 32'h2032);
    chk(lane_addr_q[95:64], 32'h2000);
    chk(wb_odd_data_q, 32'h00340000);
    $display("wrap test done");
    // modifier is half of a 2048-byte array
    pe = 32'h1000;
    po = 32'h04000000;
    load = 1'b1;
    for (i = 0; i < 4; i++) begin
      go(4'h6, 16'h0);
      chk(eff_addr_q, 32'h1000 + {16'h0, brev_seq[i]});
      chk(wb_odd_data_q, {16'h0400, brev_seq[i+1]});
    end
    $display("bit-reverse test done");
    print_verdict;
  end
endmodule // testbench

// >>> verilog/load_store_address_generator.v
// effective-address generation, write-back and trap checks for the load/store path
// Contract
// - absolute: constant top 4 bits to address top
// - absolute reaches first 16 KBytes per segment
// - short offset: register plus sign-extended 10-bit
// - long offset: register plus sign-extended 16-bit
// - displacement crossing segment raises memory trap
// - pre-increment: sum is address and write-back
// - post-increment: old address, write back sum
// - circular: base even, length/index odd halves
// - circular index advances, wraps by length
// - bytes past buffer end wrap to start
// - circular base not 64-bit aligned traps
// - length not multiple of size traps
// - index at or beyond length traps
// - circular access to peripheral space traps
// - topmost segment always counts as peripheral
// - bit-reverse: base even, index low, modifier high
// - index becomes rev(rev(I)+rev(M))
// - scaled add: data times 1,2,4,8 plus address
// - bit-index add: data>>3 plus address, clear low 2
// - jump-and-link writes next instruction address
`timescale 1ns/1ps
`include "lsag_defines.vh"
module load_store_address_generator #(
  parameter AW = 32
) (
  input  wire          clk,
  input  wire          resetn,
  input  wire          req_valid,
  input  wire [3:0]    mode,
  input  wire [1:0]    access_size,
  input  wire [17:0]   abs_const,
  input  wire [15:0]   offset,
  input  wire [1:0]    scale_sel,
  input  wire [AW-1:0] addr_even,
  input  wire [AW-1:0] addr_odd,
  input  wire [AW-1:0] data_reg,
  input  wire [AW-1:0] pc,
  input  wire [AW-1:0] jump_target,
  output reg           acc_valid_q,
  output reg  [AW-1:0] eff_addr_q,
  output reg  [255:0]  lane_addr_q,
  output reg           wb_even_q,
  output reg  [AW-1:0] wb_even_data_q,
  output reg           wb_odd_q,
  output reg  [AW-1:0] wb_odd_data_q,
  output reg           link_wr_q,
  output reg  [AW-1:0] link_data_q,
  output reg           jump_q,
  output reg  [AW-1:0] jump_addr_q,
  output reg           alignment_trap_q,
  output reg           mem_trap_q
);
  // mirror bit n onto bit 15-n of the half-word
  function [15:0] rev16;
    input [15:0] v;
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1)
        rev16[k] = v[15-k];
    end
  endfunction

  // access width in bytes; double is the default so no code is left unmapped
  function [3:0] size_bytes;
    input [1:0] s;
    begin
      case (s)
        `SIZE_BYTE: size_bytes = 4'h1;
        `SIZE_HALF: size_bytes = 4'h2;
        `SIZE_WORD: size_bytes = 4'h4;
        default:    size_bytes = 4'h8;
      endcase
    end
  endfunction

  // the short forms use only the low ten offset bits
  wire [AW-1:0] off10 = {{22{offset[9]}}, offset[9:0]};
  wire [AW-1:0] off16 = {{16{offset[15]}}, offset};
  // odd register halves: circular uses length/index, bit-reverse modifier/index
  wire [15:0]   c_len = addr_odd[31:16];
  wire [15:0]   c_idx = addr_odd[15:0];
  wire [15:0]   b_idx = addr_odd[15:0];
  wire [15:0]   b_mod = addr_odd[31:16];
  wire [3:0]    sz    = size_bytes(access_size);

  // base plus displacement; the register itself is never touched here
  wire [AW-1:0] sum10 = addr_even + off10;
  wire [AW-1:0] sum16 = addr_even + off16;
  // absolute: the top nibble of the constant selects the segment
  wire [AW-1:0] abs_ea = {abs_const[17:14], 14'h0000, abs_const[`ABS_LOW_BITS-1:0]};
  // both pair modes address base plus the unsigned index
  wire [AW-1:0] base_idx_c = addr_even + {16'h0000, c_idx};
  wire [AW-1:0] base_idx_b = addr_even + {16'h0000, b_idx};

  // circular wrap in 17 bits signed so negative steps fold back by one length
  wire [16:0] idx_step  = {1'b0, c_idx} + {offset[9], offset[9], offset[9], offset[9], offset[9], offset[9],
                                           offset[9], offset[9:0]};
  // a forward step past 64K also sets bit 16, so the sign must come from the offset
  wire        idx_neg   = offset[9] & idx_step[16];
  wire [16:0] idx_wrap  = idx_neg ? idx_step + {1'b0, c_len} :
                          (idx_step >= {1'b0, c_len}) ? idx_step - {1'b0, c_len} : idx_step;
  wire [15:0] rev_idx   = rev16(b_idx);
  wire [15:0] rev_mod   = rev16(b_mod);
  // the add carries from bit 15 downwards once mirrored back
  wire [15:0] rev_sum   = rev_idx + rev_mod;
  wire [15:0] brev_next = rev16(rev_sum);

  // alignment is tested first, so a bad pair never reaches the peripheral decode
  // low bits of length versus size; size is a power of two
  wire [15:0] sz_mask   = {12'h000, sz - 4'h1};
  wire        circ_aln  = ((addr_even & `BASE_ALIGN_MASK) != 32'h00000000) ||
                          ((c_len & sz_mask) != 16'h0000) ||
                          (c_idx >= c_len);
  wire        circ_per  = (base_idx_c[`SEG_MSB:`SEG_LSB] == `PERIPH_SEG);

  // the top nibble names the segment; a displacement may not change it
  function seg_cross;
    input [31:0] a;
    input [31:0] b;
    begin
      seg_cross = (a[31:28] != b[31:28]);
    end
  endfunction

  wire [1:0]    sh       = scale_sel;
  // scale factor is a left shift of 0 to 3 places
  wire [AW-1:0] scaled_dat = data_reg << sh;
  wire [AW-1:0] scaled     = addr_even + scaled_dat;
  // dividing by eight turns a bit number into a byte offset
  wire [AW-1:0] bit_byte   = addr_even + {3'b000, data_reg[31:3]};
  wire [AW-1:0] bit_word   = bit_byte & 32'hfffffffc;

  // next values of the output flops
  reg           v_d;
  reg           wbe_d;
  reg           wbo_d;
  reg           lnk_d;
  reg           jmp_d;
  reg           aln_d;
  reg           mem_d;
  reg           lane_ld;
  reg [AW-1:0]  ea_d;
  reg [AW-1:0]  wbe_data_d;
  reg [AW-1:0]  wbo_data_d;

  always @* begin
    v_d        = 1'b0;
    ea_d       = eff_addr_q;
    wbe_d      = 1'b0;
    wbe_data_d = wb_even_data_q;
    wbo_d      = 1'b0;
    wbo_data_d = wb_odd_data_q;
    lnk_d      = 1'b0;
    jmp_d      = 1'b0;
    aln_d      = 1'b0;
    mem_d      = 1'b0;
    lane_ld    = 1'b0;
    // nothing is issued unless a request stands at this edge
    if (req_valid) begin
      case (mode)
        // absolute: constant only, no register read
        `MODE_ABS: begin
          v_d  = 1'b1;
          ea_d = abs_ea;
        end

        // short displacement, register left as it is
        `MODE_BO_SHORT: begin
          ea_d = sum10;
          if (seg_cross(addr_even, sum10)) mem_d = 1'b1; else v_d = 1'b1;
        end

        // long displacement, same segment rule
        `MODE_BO_LONG: begin
          ea_d = sum16;
          if (seg_cross(addr_even, sum16)) mem_d = 1'b1; else v_d = 1'b1;
        end

        // pre-increment: the sum is both address and new register
        `MODE_PRE_INC: begin
          ea_d = sum10;
          if (seg_cross(addr_even, sum10)) begin
            mem_d = 1'b1;
          end else begin
            v_d        = 1'b1;
            wbe_d      = 1'b1;
            wbe_data_d = sum10;
          end
        end

        // post-increment: the old register addresses, so no crossing test applies
        `MODE_POST_INC: begin
          v_d        = 1'b1;
          ea_d       = addr_even;
          wbe_d      = 1'b1;
          wbe_data_d = sum10;
        end

        // circular: traps first, then the access and the index update
        `MODE_CIRC: begin
          ea_d = base_idx_c;
          if (circ_aln) begin
            aln_d = 1'b1;
          end else if (circ_per) begin
            mem_d = 1'b1;
          end else begin
            v_d        = 1'b1;
            lane_ld    = 1'b1;
            wbo_d      = 1'b1;
            wbo_data_d = {addr_odd[31:16], idx_wrap[15:0]};
          end
        end

        // bit-reverse: the index moves in mirrored order
        `MODE_BITREV: begin
          v_d        = 1'b1;
          ea_d       = base_idx_b;
          wbo_d      = 1'b1;
          wbo_data_d = {addr_odd[31:16], brev_next};
        end

        // scaled add: address register result only, no access
        `MODE_SCALED: begin
          wbe_d      = 1'b1;
          wbe_data_d = scaled;
        end

        // bit-index add: word address of the indexed bit
        `MODE_BITIDX: begin
          wbe_d      = 1'b1;
          wbe_data_d = bit_word;
        end

        // jump-and-link: return address and target in one cycle
        `MODE_JUMPLINK: begin
          lnk_d = 1'b1;
          jmp_d = 1'b1;
        end

        // unknown codes leave every strobe low
        default: begin
          v_d = 1'b0;
        end
      endcase
    end
  end

  // the lane table loads only when a circular access has passed its traps
  localparam LANE_COUNT = 8;
  wire [255:0] lanes;
  wrap_fetch_rom #(.LANES(LANE_COUNT)) u_wrap (
    .clk         (clk),
    .resetn      (resetn),
    .base        (addr_even),
    .index       (c_idx),
    .length      (c_len),
    .load        (lane_ld),
    .lane_addr_q (lanes)
  );

  // lane addresses are already flops inside the table
  always @* begin
    lane_addr_q = lanes;
  end

  // flags pulse for one cycle; data words hold until the next update
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_valid_q      <= 1'b0;
      eff_addr_q       <= 32'h00000000;
      wb_even_q        <= 1'b0;
      wb_even_data_q   <= 32'h00000000;
      wb_odd_q         <= 1'b0;
      wb_odd_data_q    <= 32'h00000000;
      link_wr_q        <= 1'b0;
      link_data_q      <= 32'h00000000;
      jump_q           <= 1'b0;
      jump_addr_q      <= 32'h00000000;
      alignment_trap_q <= 1'b0;
      mem_trap_q       <= 1'b0;
    end else begin
      acc_valid_q      <= v_d;
      eff_addr_q       <= ea_d;
      wb_even_q        <= wbe_d;
      wb_even_data_q   <= wbe_data_d;
      wb_odd_q         <= wbo_d;
      wb_odd_data_q    <= wbo_data_d;
      link_wr_q        <= lnk_d;
      jump_q           <= jmp_d;
      alignment_trap_q <= aln_d;
      mem_trap_q       <= mem_d;
      if (lnk_d) begin
        // link value and target land in the same cycle, so the link write is never behind the jump
        link_data_q <= pc + `NEXT_INSN_STEP;
        jump_addr_q <= jump_target;
      end
    end
  end
endmodule // load_store_address_generator

// >>> verilog/lsag_defines.vh
// constants for the load/store address generator
`ifndef LSAG_DEFINES_VH
`define LSAG_DEFINES_VH
`define MODE_ABS       4'h0
`define MODE_BO_SHORT  4'h1
`define MODE_BO_LONG   4'h2
`define MODE_PRE_INC   4'h3
`define MODE_POST_INC  4'h4
`define MODE_CIRC      4'h5
`define MODE_BITREV    4'h6
`define MODE_SCALED    4'h7
`define MODE_BITIDX    4'h8
`define MODE_JUMPLINK  4'h9
`define SIZE_BYTE      2'h0
`define SIZE_HALF      2'h1
`define SIZE_WORD      2'h2
`define SIZE_DOUBLE    2'h3
`define ABS_LOW_BITS   14
`define SEG_MSB        31
`define SEG_LSB        28
`define PERIPH_SEG     4'hf
`define BASE_ALIGN_MASK 32'h00000007
`define NEXT_INSN_STEP 32'h00000004
`endif

// >>> verilog/wrap_fetch_rom.v
// per-byte lane address table for circular accesses that run off the buffer end
`timescale 1ns/1ps
module wrap_fetch_rom #(
  parameter LANES = 8
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire [31:0] base,
  input  wire [15:0] index,
  input  wire [15:0] length,
  input  wire        load,
  output wire [255:0] lane_addr_q
);
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      localparam [16:0] LANE_STEP = g;
      // each lane owns its flop so no two processes drive one vector
      reg  [31:0] addr_q;
      wire [16:0] raw  = {1'b0, index} + LANE_STEP;
      // bytes past the end are taken from the buffer start
      wire [16:0] wrp  = (raw >= {1'b0, length}) ? raw - {1'b0, length} : raw;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          addr_q <= 32'h00000000;
        end else if (load) begin
          addr_q <= base + {16'h0000, wrp[15:0]};
        end
      end
      assign lane_addr_q[g*32 +: 32] = addr_q;
    end
  endgenerate
endmodule // wrap_fetch_rom
